// ---- logic/spc_control_top.sv ----
/*
  Control, status and register slave of the synchronous serial port,
  with one holding register each way and the shift engine below it.
  Assumes APB master on clk_in; serial pins synchronous to clk_in.
*/
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "spc_cfg.svh"
// Notes on behaviour
// [R1] Slave honours select pin only when enabled
// [R2] Interrupt forwarded only while mask bit set
// [R3] Done flag sticks until software clears it
// [R4] Data input readback delayed two clocks
// [R5] Transmit full flag while holding occupied
// [R6] Force bit drives output to level bit
// [R7] Idle output sits at level bit
// [R8] Soft reset acts like off, clock runs
// [R9] Word field picks 8, 16, 32, 9 bits; in the slave role the 9-bit code gives 8 bits
// [R10] Role bit: master or slave, first instance
// [R11] Clock rate is divider times 8,4,2,14
// [R12] Polarity sets serial clock idle level
// [R13] Phase picks launch and sample edges
// [R14] Off resets everything but control registers
// [R15] Master drains shift and holding before stopping
// [R16] Software sets on bit in separate write
// [R17] Any write to clear register clears flag
// [R18] One bit shifted each serial clock period
// [R19] Control fields reset to zero
module spc_control_top #(
  parameter int        DIV_W      = 8,
  parameter bit        FIRST_INST = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output var  logic        pready_out,
  output var  logic        pslverr_out,
  input  wire logic        sclk_in,
  output var  logic        sclk_out,
  output var  logic        sclk_oe_out,
  input  wire logic        sdi_in,
  output var  logic        sdo_out,
  input  wire logic        sel_n_in,
  output var  logic        irq_out
);
  import spc_pkg::*;

  spc_eng_if eng_if ();

  logic [15:0]      ctrl;
  logic [DIV_W-1:0] clk_div;
  logic [31:0]      hold;
  logic [15:0]      hold_hi;
  logic             hold_v;
  logic [31:0]      rx;
  logic [1:0]       st;
  logic             mask1;
  logic             di_s1;
  logic             di_s2;
  logic             slave;
  logic             kill;
  logic             acc;
  logic             wr;
  logic             mapped;
  logic             wr_ctrl;
  logic             wr_data0;
  logic             wr_data1;
  logic             wr_clr;
  logic             wr_div;
  logic             wr_stat;
  logic             wr_mask;
  logic             overrun;
  logic [31:0]      next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign slave   = ctrl[`SPC_B_ROLE] & FIRST_INST;    // [R10]
  // Off drains a master first; slave and soft reset stop at once
  assign kill    = ctrl[`SPC_B_RST]                    // [R8]
                 | (!ctrl[`SPC_B_ON] & (slave | (!eng_if.busy & !hold_v))); // [R14] [R15]

  // Engine hookup
  assign eng_if.start    = hold_v;
  assign eng_if.tx_word  = hold;
  assign eng_if.bits     = spc_word_bits(ctrl[8:7], slave); // [R9]
  assign eng_if.pol      = ctrl[`SPC_B_POL];
  assign eng_if.pha      = ctrl[`SPC_B_PHA];
  assign eng_if.slave    = slave;
  assign eng_if.sel_ok   = !ctrl[`SPC_B_EN_CTRL] | !sel_n_in; // [R1]
  assign eng_if.sclk_pin = sclk_in;
  assign eng_if.sdi      = sdi_in;
  assign eng_if.kill     = kill;
  assign eng_if.half     = spc_half(8'(clk_div), ctrl[4:3]); // [R11]

  spc_engine u_engine (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .e        (eng_if.eng)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; write lands on the edge that completes the access
  assign acc      = psel_in & penable_in & pready_out;
  assign wr       = acc & pwrite_in;
  assign mapped   = (paddr_in == `SPC_CTRL_ADDR) || (paddr_in == `SPC_DATA0_ADDR)
                 || (paddr_in == `SPC_DATA1_ADDR) || (paddr_in == `SPC_CLRINT_ADDR)
                 || (paddr_in == `SPC_CLKDIV_ADDR) || (paddr_in == `SPC_STAT_ADDR)
                 || (paddr_in == `SPC_MASK_ADDR);
  assign wr_ctrl  = wr && (paddr_in == `SPC_CTRL_ADDR);
  assign wr_data0 = wr && (paddr_in == `SPC_DATA0_ADDR);
  assign wr_data1 = wr && (paddr_in == `SPC_DATA1_ADDR);
  assign wr_clr   = wr && (paddr_in == `SPC_CLRINT_ADDR);
  assign wr_div   = wr && (paddr_in == `SPC_CLKDIV_ADDR);
  assign wr_stat  = wr && (paddr_in == `SPC_STAT_ADDR);
  assign wr_mask  = wr && (paddr_in == `SPC_MASK_ADDR);
  assign overrun  = wr_data0 && hold_v;

  // Read mux; clear register and unmapped read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_in)
      `SPC_CTRL_ADDR: begin
        next_rdata = {16'h0000, ctrl[15:14], st[0], di_s2, hold_v, ctrl[10:0]}; // [R3] [R4] [R5]
      end
      `SPC_DATA0_ADDR:  next_rdata = {16'h0000, rx[15:0]};
      `SPC_DATA1_ADDR:  next_rdata = {16'h0000, rx[31:16]};
      `SPC_CLRINT_ADDR: next_rdata = 32'h0000_0000;  // [R17]
      `SPC_CLKDIV_ADDR: next_rdata = 32'(clk_div);
      `SPC_STAT_ADDR:   next_rdata = {30'h0000_0000, st};
      `SPC_MASK_ADDR:   next_rdata = {30'h0000_0000, mask1, ctrl[`SPC_B_MASK]};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // One wait state per access: answer registered, so it is glitch free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & !pready_out;
      pslverr_out <= psel_in & penable_in & !pready_out & !mapped;
      if (psel_in & penable_in & !pready_out & !pwrite_in) begin
        prdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; read-only bits stay out of storage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= `SPC_CTRL_RESET;                         // [R19]
    end else if (wr_ctrl) begin
      ctrl <= pwdata_in[15:0] & `SPC_CTRL_WMASK;
    end else if (wr_mask) begin
      ctrl[`SPC_B_MASK] <= pwdata_in[0];
    end
  end

  // Divider and overrun mask survive switch-off like control
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_div <= DIV_W'(`SPC_DIV_RESET);
      mask1   <= 1'b0;
    end else begin
      if (wr_div) begin
        clk_div <= pwdata_in[DIV_W-1:0];
      end
      if (wr_mask) begin
        mask1 <= pwdata_in[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding: high half staged first, low half commits the word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold    <= 32'h0000_0000;
      hold_hi <= 16'h0000;
      hold_v  <= 1'b0;
    end else if (kill) begin
      hold_hi <= 16'h0000;                             // [R14]
      hold_v  <= 1'b0;
    end else begin
      if (wr_data1) begin
        hold_hi <= pwdata_in[15:0];
      end
      if (wr_data0 && !hold_v) begin
        hold   <= {(ctrl[8:7] == SPC_W32) ? hold_hi : 16'h0000, pwdata_in[15:0]};
        hold_v <= 1'b1;                                // [R5]
      end else if (eng_if.take) begin
        hold_v <= 1'b0;
      end
    end
  end

  // Receive word kept until the next one lands or kill clears it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx <= 32'h0000_0000;
    end else if (kill) begin
      rx <= 32'h0000_0000;                             // [R14]
    end else if (eng_if.done) begin
      rx <= eng_if.rx_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a set in the clear cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= 2'b00;
    end else if (kill) begin
      st <= 2'b00;                                     // [R14]
    end else begin
      if (eng_if.done) begin
        st[0] <= 1'b1;                                 // [R3]
      end else if (wr_clr || (wr_stat && pwdata_in[0])) begin
        st[0] <= 1'b0;                                 // [R17]
      end
      if (overrun) begin
        st[1] <= 1'b1;
      end else if (wr_stat && pwdata_in[1]) begin
        st[1] <= 1'b0;
      end
    end
  end

  // Level interrupt, gated by the mask bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (st[0] & ctrl[`SPC_B_MASK]) | (st[1] & mask1); // [R2]
    end
  end

  // Input pin readback pipeline, two stages deep
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
    end else begin
      di_s1 <= sdi_in;
      di_s2 <= di_s1;                                  // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered; costs one clock of latency on each pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_out    <= 1'b0;
      sclk_oe_out <= 1'b0;
      sdo_out     <= 1'b0;
    end else begin
      sclk_out    <= slave ? ctrl[`SPC_B_POL] : eng_if.sclk;
      sclk_oe_out <= !slave;
      if (ctrl[`SPC_B_FORCE]) begin
        sdo_out <= ctrl[`SPC_B_DOLVL];                 // [R6]
      end else if (!eng_if.busy) begin
        sdo_out <= ctrl[`SPC_B_DOLVL];                 // [R7]
      end else begin
        sdo_out <= eng_if.dout;                        // [R18]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_irq_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
    (!ctrl[`SPC_B_MASK] && !mask1) |=> !irq_out)
    else $error("interrupt raised while masked");
  a_done_sticks: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
    (eng_if.done && !kill) |=> st[0] ##1 (st[0] || $past(wr_clr || wr_stat || kill)))
    else $error("done flag lost");
  a_clear_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R17]
    (wr_clr && !eng_if.done) |=> !st[0])
    else $error("clear write left flag set");
  a_di_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
    ##2 (di_s2 == $past(sdi_in, 2)))
    else $error("readback not two clocks behind pin");
  a_txfull_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
    (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == `SPC_CTRL_ADDR)
      |=> (prdata_out[11] == $past(hold_v)))
    else $error("full flag read wrong");
  a_force_do: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R6]
    ctrl[`SPC_B_FORCE] |=> (sdo_out == $past(ctrl[`SPC_B_DOLVL])))
    else $error("forced output level wrong");
  a_idle_do: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R7]
    (!eng_if.busy && !ctrl[`SPC_B_FORCE]) |=> (sdo_out == $past(ctrl[`SPC_B_DOLVL])))
    else $error("idle output level wrong");
  a_soft_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
    ctrl[`SPC_B_RST] |=> (!eng_if.busy && !hold_v && st == 2'b00))
    else $error("soft reset left state");
  a_slave_arm: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
    (slave && !ctrl[`SPC_B_EN_CTRL] && !eng_if.busy && !kill) |=> eng_if.busy)
    else $error("slave did not ignore select pin");
  a_off_drain: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R15]
    (!ctrl[`SPC_B_ON] && !ctrl[`SPC_B_RST] && !slave && eng_if.busy && !eng_if.done)
      |=> (eng_if.busy || eng_if.done))
    else $error("master stopped before draining");
  a_off_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
    (!ctrl[`SPC_B_ON] && (slave || (!eng_if.busy && !hold_v))) |=> (st == 2'b00 && !eng_if.busy))
    else $error("switch-off did not reset state");

  c_master_word: cover property (@(posedge clk_in) disable iff (!rst_n_in) eng_if.done && !slave);
  c_slave_word: cover property (@(posedge clk_in) disable iff (!rst_n_in) eng_if.done && slave);
  c_overrun: cover property (@(posedge clk_in) disable iff (!rst_n_in) overrun);
  c_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) irq_out);
endmodule : spc_control_top
`default_nettype wire

// ---- logic/spc_cfg.svh ----
/*
  Register addresses, field positions, reset values and clock-rate
  multipliers of the serial port control block.
  Assumes a 32-bit APB with byte addresses; included by bare name.
*/
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_CTRL_ADDR   32'h5000_1200
`define SPC_DATA0_ADDR  32'h5000_1204
`define SPC_DATA1_ADDR  32'h5000_1208
`define SPC_CLRINT_ADDR 32'h5000_120C
`define SPC_CLKDIV_ADDR 32'h5000_1210
`define SPC_STAT_ADDR   32'h5000_1214
`define SPC_MASK_ADDR   32'h5000_1218
`define SPC_B_EN_CTRL   15
`define SPC_B_MASK      14
`define SPC_B_FORCE     10
`define SPC_B_RST       9
`define SPC_B_ROLE      6
`define SPC_B_DOLVL     5
`define SPC_B_POL       2
`define SPC_B_PHA       1
`define SPC_B_ON        0
`define SPC_CTRL_RESET  16'h0000
`define SPC_CTRL_WMASK  16'hC7FF
`define SPC_DIV_RESET   8'h01
`define SPC_HALF_X8     16'h0004
`define SPC_HALF_X4     16'h0002
`define SPC_HALF_X2     16'h0001
`define SPC_HALF_X14    16'h0007
`endif

// ---- logic/spc_pkg.sv ----
/*
  Types and shared decode functions of the serial port control block.
  Assumes spc_cfg.svh is on the include path.
*/
`default_nettype none
package spc_pkg;
  `include "spc_cfg.svh"

  typedef enum logic [1:0] {
    SPC_W8  = 2'b00,
    SPC_W16 = 2'b01,
    SPC_W32 = 2'b10,
    SPC_W9  = 2'b11
  } spc_word_e;

  typedef enum logic {
    SPC_IDLE = 1'b0,
    SPC_XFER = 1'b1
  } spc_state_e;

  // Word length in bits; nine bits only as master
  function automatic logic [5:0] spc_word_bits(input logic [1:0] w, input logic slave);
    case (spc_word_e'(w))
      SPC_W8:  spc_word_bits = 6'h08;
      SPC_W16: spc_word_bits = 6'h10;
      SPC_W32: spc_word_bits = 6'h20;
      SPC_W9:  spc_word_bits = slave ? 6'h08 : 6'h09;
      default: spc_word_bits = 6'h08;
    endcase
  endfunction : spc_word_bits

  // Half serial period in system clocks; divider zero acts as one
  function automatic logic [15:0] spc_half(input logic [7:0] div, input logic [1:0] code);
    logic [15:0] d;
    logic [15:0] m;
    d = (div == 8'h00) ? 16'h0001 : {8'h00, div};
    case (code)
      2'b00:   m = `SPC_HALF_X8;
      2'b01:   m = `SPC_HALF_X4;
      2'b10:   m = `SPC_HALF_X2;
      default: m = `SPC_HALF_X14;
    endcase
    spc_half = d * m;
  endfunction : spc_half
endpackage : spc_pkg
`default_nettype wire

// ---- logic/spc_eng_if.sv ----
/*
  Signals between the control registers and the serial shift engine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface spc_eng_if;
  logic        start;
  logic [31:0] tx_word;
  logic [5:0]  bits;
  logic        pol;
  logic        pha;
  logic        slave;
  logic        sel_ok;
  logic        sclk_pin;
  logic        sdi;
  logic        kill;
  logic [15:0] half;
  logic        busy;
  logic        done;
  logic        take;
  logic        dout;
  logic        sclk;
  logic [31:0] rx_word;

  modport ctl (output start, tx_word, bits, pol, pha, slave, sel_ok, sclk_pin, sdi, kill, half,
               input busy, done, take, dout, sclk, rx_word);
  modport eng (input start, tx_word, bits, pol, pha, slave, sel_ok, sclk_pin, sdi, kill, half,
               output busy, done, take, dout, sclk, rx_word);
endinterface : spc_eng_if
`default_nettype wire

// ---- logic/spc_engine.sv ----
/*
  Serial shift engine: rate divider, clock edges, launch and sample.
  Assumes serial pins already synchronous to clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_engine (
  input wire logic clk_in,
  input wire logic rst_n_in,
  spc_eng_if.eng   e
);
  import spc_pkg::*;

  spc_state_e  state;
  logic [15:0] cnt;
  logic [6:0]  ecnt;
  logic [6:0]  last;
  logic [31:0] txsh;
  logic [31:0] rxsh;
  logic        sclk_q;
  logic        tick;
  logic        edge_ev;
  logic        sample;
  logic        launch;

  // Edge decode; even edges are leading
  assign tick    = (cnt >= e.half - 16'h0001);
  assign last    = {e.bits, 1'b0} - 7'h01;
  assign sample  = (ecnt[0] == e.pha);                // [R13]
  assign launch  = !sample && (ecnt != 7'h00);
  assign edge_ev = (state == SPC_XFER) && (e.slave ? (e.sel_ok && sclk_q != e.sclk_pin) : tick);
  assign e.busy  = (state == SPC_XFER);
  assign e.dout  = txsh[5'(e.bits - 6'h01)];           // Msb first

  ////////////////////////////////////////////////////////////////////////////
  // Divider runs even under soft reset, so the internal clock never stops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 16'h0000;
    end else if (tick) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;                           // [R11]
    end
  end

  // Previous slave clock level for edge detect
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= e.sclk_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= SPC_IDLE;
      ecnt      <= 7'h00;
      txsh      <= 32'h0000_0000;
      rxsh      <= 32'h0000_0000;
      e.sclk    <= 1'b0;
      e.done    <= 1'b0;
      e.take    <= 1'b0;
      e.rx_word <= 32'h0000_0000;
    end else begin
      e.done <= 1'b0;
      e.take <= 1'b0;
      if (e.kill || (e.busy && e.slave && !e.sel_ok)) begin
        state  <= SPC_IDLE;
        ecnt   <= 7'h00;
        e.sclk <= e.pol;
      end else if (state == SPC_IDLE) begin
        e.sclk <= e.pol;                               // [R12]
        ecnt   <= 7'h00;
        if (e.slave ? e.sel_ok : e.start) begin
          state  <= SPC_XFER;
          txsh   <= e.start ? e.tx_word : 32'h0000_0000;
          rxsh   <= 32'h0000_0000;
          e.take <= e.start;
        end
      end else if (edge_ev) begin
        e.sclk <= ~e.sclk;
        ecnt   <= ecnt + 7'h01;
        if (sample) begin
          rxsh <= {rxsh[30:0], e.sdi};                 // [R18]
        end
        if (launch) begin
          txsh <= {txsh[30:0], 1'b0};                  // [R18]
        end
        if (ecnt == last) begin
          state     <= SPC_IDLE;
          e.done    <= 1'b1;
          e.rx_word <= sample ? {rxsh[30:0], e.sdi} : rxsh;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sclk_idle_lvl: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
    (state == SPC_IDLE) |=> (e.sclk == $past(e.pol)))
    else $error("serial clock not at idle level");
  a_word_end: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R18]
    (edge_ev && ecnt == last && !e.kill && !(e.slave && !e.sel_ok)) |=> (state == SPC_IDLE && e.done))
    else $error("word did not end after its last edge");
  a_sample_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
    (edge_ev && sample && ecnt != last && !e.kill && !(e.slave && !e.sel_ok)) |=> (rxsh[0] == $past(e.sdi)))
    else $error("input bit not captured on sample edge");
endmodule : spc_engine
`default_nettype wire

// ---- verif/spc_peer_model.sv ----
/*
  Far-side serial peripheral model: shifts a loaded word out msb first
  and captures what the block sends, in any polarity and phase.
  Assumes sclk and sdo come from the block in its master role.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_peer_model (
  input  wire logic        sclk_in,
  input  wire logic        sdo_in,
  input  wire logic        pol_in,
  input  wire logic        pha_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_word_in,
  output var  logic        sdi_out,
  output var  logic [31:0] rx_out,
  output var  logic [5:0]  nbits_out
);
  logic [31:0] txq   = 32'h0000_0000;
  logic        first = 1'b1;
  wire         lead  = sclk_in ^ pol_in; // Leading edge follows idle level
  initial rx_out    = 32'h0000_0000;
  initial nbits_out = 6'h00;
  assign sdi_out = txq[31];
  ////////////////////////////////////////////////////////////////////////
  // New word: capture starts empty
  always @(posedge load_in) begin
    txq       = load_word_in;
    rx_out    = 32'h0000_0000;
    nbits_out = 6'h00;
    first     = 1'b1;
  end
  // Fill with inverted bits so a stale level never looks valid
  always @(posedge lead) begin
    if (!pha_in) begin
      rx_out    = {rx_out[30:0], sdo_in};
      nbits_out = nbits_out + 6'h01;
    end else if (!first) begin
      txq = {txq[30:0], ~txq[0]};
    end
    first = 1'b0;
  end
  // Trailing edge: the other half of the exchange
  always @(negedge lead) begin
    if (pha_in) begin
      rx_out    = {rx_out[30:0], sdo_in};
      nbits_out = nbits_out + 6'h01;
    end else begin
      txq = {txq[30:0], ~txq[0]};
    end
  end
endmodule : spc_peer_model
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
  Bench of the serial port control block: APB register tasks and
  transfers in every word, rate and clock mode against the peer model.
  Assumes the design sources, spc_cfg.svh and the peer model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spc_cfg.svh"
module tb_top;
  localparam int BITS [4] = '{8, 16, 32, 9};
  localparam int MULT [4] = '{4, 2, 1, 7};
  logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, peer_rx, load_word;
  logic        sclk, sclk_oe, sdi, sdo, irq, pol_v, pha_v, load, lead_q;
  logic [5:0]  peer_nbits;
  int          err_total, n_checks, cnt, per;

  spc_control_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sclk_in(1'b0), .sclk_out(sclk), .sclk_oe_out(sclk_oe), .sdi_in(sdi),
    .sdo_out(sdo), .sel_n_in(1'b1), .irq_out(irq));
  spc_peer_model peer_u (.sclk_in(sclk), .sdo_in(sdo), .pol_in(pol_v), .pha_in(pha_v), .load_in(load),
    .load_word_in(load_word), .sdi_out(sdi), .rx_out(peer_rx), .nbits_out(peer_nbits));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #800000;
    err_total++;
    wrap_up();
  end
  // Serial clock period between leading edges
  always @(posedge clk_in) begin
    lead_q <= sclk ^ pol_v;
    cnt    <= cnt + 1;
    if ((sclk ^ pol_v) && !lead_q) begin
      per <= cnt + 1;
      cnt <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One APB transfer; an idle edge first keeps drives one per time step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
  endtask : apb
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask : w
  task automatic r(input logic [31:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : r
  task automatic peer_load(input logic [31:0] v);
    @(posedge clk_in);
    load_word <= v;
    load      <= 1'b1;
    @(posedge clk_in);
    load      <= 1'b0;
  endtask : peer_load
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d, m, txw, expv;
    logic        e;
    logic [15:0] c;
    int          n;
    {psel, penable, pwrite, paddr, pwdata, load, load_word} = '0;
    {pol_v, pha_v, lead_q, cnt, per, err_total, n_checks} = '0;
    rst_n_in = 1'b0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    r(`SPC_CTRL_ADDR, d);
    check("ctrl reset", d, 32'h0);
    r(`SPC_CLKDIV_ADDR, d);
    check("div reset", d, 32'h1);
    apb(1'b0, 32'h5000_121C, 32'h0, d, e);
    check("unmapped err", e, 1'b1);
    w(`SPC_CTRL_ADDR, 32'hFFFF_C7FE);
    r(`SPC_CTRL_ADDR, d);
    check("ctrl rw", d, 32'h0000_C7FE);
    w(`SPC_CTRL_ADDR, 32'h0400);
    repeat (3) @(posedge clk_in);
    check("force low", sdo, 1'b0);
    w(`SPC_CTRL_ADDR, 32'h0420);
    repeat (3) @(posedge clk_in);
    check("force high", sdo, 1'b1);
    w(`SPC_CTRL_ADDR, 32'h0);
    peer_load(32'h8000_0000);
    r(`SPC_CTRL_ADDR, d);
    check("din high", d[12], 1'b1);
    peer_load(32'h0);
    r(`SPC_CTRL_ADDR, d);
    check("din low", d[12], 1'b0);
    // Every word length, rate code and clock mode once
    for (int i = 0; i < 4; i++) begin
      m = (BITS[i] == 32) ? 32'hFFFF_FFFF : ((32'h1 << BITS[i]) - 32'h1);
      txw = 32'hA5C3_96E1 & m;
      expv = 32'h3C5A_E187 >> (32 - BITS[i]);
      c = 16'h0020 | 16'(i << 7) | 16'(i << 3) | 16'(i << 1) | ((i != 2) ? 16'h4000 : 16'h0000);
      pol_v = i[1];
      pha_v = i[0];
      w(`SPC_CLKDIV_ADDR, 32'h2);
      w(`SPC_CTRL_ADDR, {16'h0, c});
      w(`SPC_CTRL_ADDR, {16'h0, c | 16'h0001});
      peer_load(32'h3C5A_E187);
      check("sclk idle", sclk, pol_v);
      check("sclk drive", sclk_oe, 1'b1);
      check("sdo idle", sdo, 1'b1);
      if (BITS[i] == 32) w(`SPC_DATA1_ADDR, {16'h0, txw[31:16]});
      w(`SPC_DATA0_ADDR, {16'h0, txw[15:0]});
      n = 0;
      do begin
        r(`SPC_CTRL_ADDR, d);
        n++;
      end while (d[13] !== 1'b1 && n < 300);
      check("done set", n < 300, 1'b1);
      check("peer data", peer_rx, txw);
      check("rate", per, 4 * MULT[i]);
      check("irq on", irq, i != 2);
      r(`SPC_DATA0_ADDR, d);
      check("rx low", d[15:0] & m[15:0], expv[15:0] & m[15:0]);
      if (BITS[i] == 32) begin
        r(`SPC_DATA1_ADDR, d);
        check("rx high", d[15:0], expv[31:16]);
      end
      check("sdo after", sdo, 1'b1);
      w(`SPC_CLRINT_ADDR, 32'h5A5A);
      r(`SPC_CTRL_ADDR, d);
      check("done clear", d[13], 1'b0);
      check("irq off", irq, 1'b0);
      r(`SPC_CLRINT_ADDR, d);
      check("clr read", d, 32'h0);
      w(`SPC_CTRL_ADDR, {16'h0, c});
    end
    // Two words queued, then switched off mid-transfer
    pol_v = 1'b0;
    pha_v = 1'b0;
    w(`SPC_CTRL_ADDR, 32'h0018);
    w(`SPC_CTRL_ADDR, 32'h0019);
    peer_load(32'h0);
    w(`SPC_DATA0_ADDR, 32'h5A);
    w(`SPC_DATA0_ADDR, 32'hC3);
    r(`SPC_CTRL_ADDR, d);
    check("tx full", d[11], 1'b1);
    w(`SPC_CTRL_ADDR, 32'h0018);
    n = 0;
    while (peer_nbits !== 6'd16 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    check("drained", peer_rx, 32'h5AC3);
    repeat (40) @(posedge clk_in);
    r(`SPC_CTRL_ADDR, d);
    check("off flags", {d[13], d[11]}, 2'b00);
    r(`SPC_DATA0_ADDR, d);
    check("off rx", d[15:0], 16'h0000);
    w(`SPC_CTRL_ADDR, 32'h0019);
    w(`SPC_DATA0_ADDR, 32'h5A);
    w(`SPC_DATA0_ADDR, 32'hC3);
    w(`SPC_CTRL_ADDR, 32'h0219);
    r(`SPC_CTRL_ADDR, d);
    check("soft reset", {d[13], d[11]}, 2'b00);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
